// *** rtl/clock_power_pkg.sv ***
// Shared constants and types for the system clock and power mode controller
package clock_power_pkg;

    // Clock rates
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int FAST_OSC_HZ = 8_000_000;
    localparam int SLOW_OSC_HZ = 32_000;

    // Half periods of each oscillator in sys_clk cycles, rounded down
    localparam int FAST_HALF_CYCLES = SYS_CLK_HZ / (2 * FAST_OSC_HZ);
    localparam int SLOW_HALF_CYCLES = SYS_CLK_HZ / (2 * SLOW_OSC_HZ);

    // Quiet time, in half periods, after which an oscillator counts as lost
    localparam int EDGE_TIMEOUT_HALVES = 4;
    localparam int FAST_EDGE_TIMEOUT_CYCLES = EDGE_TIMEOUT_HALVES * FAST_HALF_CYCLES;
    localparam int SLOW_EDGE_TIMEOUT_CYCLES = EDGE_TIMEOUT_HALVES * SLOW_HALF_CYCLES;

    // Edges seen before an oscillator is treated as stable
    localparam logic [7:0] FAST_STABLE_EDGES = 8'h20;
    localparam logic [7:0] SLOW_STABLE_EDGES = 8'h04;

    // Register offsets
    localparam logic [7:0] MODE_CTRL_ADDR = 8'h00;
    localparam logic [7:0] MODE_CTRL_EXT_ADDR = 8'h01;
    localparam logic [7:0] MODE_STATUS_ADDR = 8'h02;

    // Field positions in the mode control register
    localparam int DIV_SEL_LSB = 5;
    localparam int SLOW_READY_BIT = 3;
    localparam int FAST_READY_BIT = 2;
    localparam int IDLE_ON_HALT_BIT = 1;
    localparam int FAST_SEL_BIT = 0;
    // Field position in the extended mode control register
    localparam int KEEP_SYSCLK_BIT = 7;

    // Values after reset
    localparam logic [2:0] DIV_SEL_RESET = 3'h0;
    localparam logic IDLE_ON_HALT_RESET = 1'b1;
    localparam logic FAST_SEL_RESET = 1'b1;
    localparam logic KEEP_SYSCLK_RESET = 1'b0;

    // Divider select codes at or below this pick the slow clock
    localparam logic [2:0] DIV_SEL_SLOW_MAX = 3'h1;
    // Divide shift is this minus the divider select code
    localparam logic [3:0] DIV_SHIFT_BASE = 4'h8;

    // Operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_NORMAL = 6'h01,
        MODE_SLOW = 6'h02,
        MODE_IDLE_STOPPED = 6'h04,
        MODE_IDLE_RUNNING = 6'h08,
        MODE_STOP_WATCHDOG = 6'h10,
        MODE_DEEP_STOP = 6'h20
    } mode_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Generated clocks
    typedef struct packed {
        logic system_clock;
        logic cpu_clock;
        logic timebase_clock;
        logic watchdog_clock;
    } clk_out_t;

    // Oscillator enables
    typedef struct packed {
        logic fast_osc_enable;
        logic slow_osc_enable;
    } osc_ctrl_t;

endpackage

// *** rtl/osc_edge_tracker.sv ***
// Oscillator pin synchroniser, edge detector and stability tracker
`timescale 1ns/100ps
module osc_edge_tracker #(
    parameter logic [7:0] STABLE_EDGES = 8'h04,
    parameter int EDGE_TIMEOUT = 24
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Oscillator pin and its enable
    input wire logic osc_pin,
    input wire logic osc_enable,
    // Edge pulse and ready level
    output logic osc_edge,
    output logic osc_ready
);
    import clock_power_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic edge_seen;
        logic ready;
        logic [7:0] stable_cnt;
        logic [15:0] quiet_cnt;
    } track_state_t;

    track_state_t r_reg;
    track_state_t r_next;

    // Edge counting, stability and loss detection
    always_comb begin
        r_next = r_reg;
        r_next.sync1 = osc_pin;
        r_next.sync2 = r_reg.sync1;
        r_next.prev = r_reg.sync2;
        r_next.edge_seen = osc_enable && (r_reg.sync2 != r_reg.prev);
        if (!osc_enable) begin
            r_next.stable_cnt = 8'h00;
            r_next.quiet_cnt = 16'h0000;
            r_next.ready = 1'b0;
        end else if (r_reg.sync2 != r_reg.prev) begin
            r_next.quiet_cnt = 16'h0000;
            if (r_reg.stable_cnt != STABLE_EDGES) begin
                r_next.stable_cnt = r_reg.stable_cnt + 8'h01;
            end else begin
                r_next.ready = 1'b1;
            end
        end else if (r_reg.quiet_cnt == 16'(EDGE_TIMEOUT)) begin
            r_next.stable_cnt = 8'h00; // Oscillator lost, start over
            r_next.ready = 1'b0;
        end else begin
            r_next.quiet_cnt = r_reg.quiet_cnt + 16'h0001;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    assign osc_edge = r_reg.edge_seen;
    assign osc_ready = r_reg.ready;

endmodule

// *** rtl/clock_power_ctrl.sv ***
// System clock selection and operating mode controller
// Operation
// - Fast clock from internal 8MHz RC oscillator
// - Slow clock from internal 32kHz RC oscillator
// - Slow oscillator also clocks watchdog and timebase
// - System clock: fast, fast/2..64, or slow
// - Timebase clock derived from slow oscillator
// - Moving to slow clock stops fast oscillator
// - Normal mode: CPU on fast or divided fast clock
// - Slow mode: CPU on slow clock, fast off
// - Halt with idle off enters a sleep mode
// - Deep stop halts all clocks and watchdog
// - Stop-with-watchdog keeps slow oscillator for watchdog
// - Halt, idle on, keep off: idle stopped
// - Idle stopped: system clock off, timebase runs
// - Halt, idle on, keep on: idle running
// - Idle running: system clock on, CPU off
// - Divider select codes map slow or fast/64..2
// - Fast select high picks undivided fast clock
`timescale 1ns/100ps
module clock_power_ctrl #(
    parameter int SLOW_TIMEOUT_CYCLES = clock_power_pkg::SLOW_EDGE_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register port
    input wire clock_power_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Oscillator pins and enables
    input wire logic fast_rc_osc,
    input wire logic slow_rc_osc,
    output clock_power_pkg::osc_ctrl_t osc_ctrl,
    // CPU and watchdog controls
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic watchdog_enable,
    // Generated clocks and mode
    output clock_power_pkg::clk_out_t clk_out,
    output clock_power_pkg::mode_t mode_status
);
    import clock_power_pkg::*;

    typedef struct packed {
        mode_t mode;
        logic [2:0] divider_select;
        logic idle_on_halt;
        logic fast_clock_select;
        logic keep_sysclk_in_idle;
        logic active_fast;
        logic [2:0] active_shift;
        logic [5:0] div_cnt;
        clk_out_t clk;
        osc_ctrl_t osc;
        logic [7:0] rdata;
    } ctrl_state_t;

    ctrl_state_t r_reg;
    ctrl_state_t r_next;

    logic fast_edge;
    logic fast_ready;
    logic slow_edge;
    logic slow_ready;

    // True when the selection needs the fast oscillator
    function automatic logic needs_fast(input logic fcs, input logic [2:0] sel);
        needs_fast = fcs || (sel > DIV_SEL_SLOW_MAX);
    endfunction

    // Divide shift: 0 undivided, 6..1 for /64../2
    function automatic logic [2:0] target_shift(input logic fcs, input logic [2:0] sel);
        if (fcs || sel <= DIV_SEL_SLOW_MAX) begin
            target_shift = 3'h0;
        end else begin
            target_shift = 3'(DIV_SHIFT_BASE - {1'b0, sel});
        end
    endfunction

    // Mask of low divider bits for a shift
    function automatic logic [5:0] div_mask(input logic [2:0] shift);
        div_mask = 6'((7'h01 << shift) - 7'h01);
    endfunction

    // Fast oscillator tracker
    osc_edge_tracker #(
        .STABLE_EDGES(FAST_STABLE_EDGES),
        .EDGE_TIMEOUT(FAST_EDGE_TIMEOUT_CYCLES)
    ) fast_tracker (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .osc_pin(fast_rc_osc),
        .osc_enable(r_reg.osc.fast_osc_enable),
        .osc_edge(fast_edge),
        .osc_ready(fast_ready)
    );

    // Slow oscillator tracker
    osc_edge_tracker #(
        .STABLE_EDGES(SLOW_STABLE_EDGES),
        .EDGE_TIMEOUT(SLOW_TIMEOUT_CYCLES)
    ) slow_tracker (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .osc_pin(slow_rc_osc),
        .osc_enable(r_reg.osc.slow_osc_enable),
        .osc_edge(slow_edge),
        .osc_ready(slow_ready)
    );

    logic run_mode;
    logic want_fast;
    logic [2:0] want_shift;
    logic src_toggle;
    logic sys_run;
    logic cpu_run;
    logic tb_run;
    logic wd_run;
    logic [5:0] mask;
    logic src_on;

    // Next state: registers, source switch, mode, clocks
    always_comb begin
        r_next = r_reg;
        r_next.rdata = 8'h00;
        run_mode = (r_reg.mode == MODE_NORMAL) || (r_reg.mode == MODE_SLOW);

        // Register writes and reads
        if (reg_req.wr) begin
            if (reg_req.addr == MODE_CTRL_ADDR) begin
                r_next.divider_select = reg_req.wdata[DIV_SEL_LSB +: 3];
                r_next.idle_on_halt = reg_req.wdata[IDLE_ON_HALT_BIT];
                r_next.fast_clock_select = reg_req.wdata[FAST_SEL_BIT];
            end else if (reg_req.addr == MODE_CTRL_EXT_ADDR) begin
                r_next.keep_sysclk_in_idle = reg_req.wdata[KEEP_SYSCLK_BIT];
            end
        end else if (reg_req.rd) begin
            if (reg_req.addr == MODE_CTRL_ADDR) begin
                r_next.rdata[DIV_SEL_LSB +: 3] = r_reg.divider_select;
                r_next.rdata[SLOW_READY_BIT] = slow_ready;
                r_next.rdata[FAST_READY_BIT] = fast_ready;
                r_next.rdata[IDLE_ON_HALT_BIT] = r_reg.idle_on_halt;
                r_next.rdata[FAST_SEL_BIT] = r_reg.fast_clock_select;
            end else if (reg_req.addr == MODE_CTRL_EXT_ADDR) begin
                r_next.rdata[KEEP_SYSCLK_BIT] = r_reg.keep_sysclk_in_idle;
            end else if (reg_req.addr == MODE_STATUS_ADDR) begin
                r_next.rdata = {2'h0, r_reg.mode};
            end
        end

        // Requested source, applied at a low phase once stable
        want_fast = needs_fast(r_reg.fast_clock_select, r_reg.divider_select);
        want_shift = target_shift(r_reg.fast_clock_select, r_reg.divider_select);
        r_next.div_cnt = fast_edge ? r_reg.div_cnt + 6'h01 : r_reg.div_cnt;
        if (run_mode && !r_reg.clk.system_clock
                && (want_fast != r_reg.active_fast || want_shift != r_reg.active_shift)
                && (want_fast ? fast_ready : slow_ready)) begin
            r_next.active_fast = want_fast;
            r_next.active_shift = want_shift;
            r_next.div_cnt = 6'h00;
        end

        // Mode sequencing
        case (r_reg.mode)
            MODE_NORMAL, MODE_SLOW: begin
                if (halt_req && !r_reg.idle_on_halt) begin
                    r_next.mode = watchdog_enable ? MODE_STOP_WATCHDOG : MODE_DEEP_STOP;
                end else if (halt_req && !r_reg.keep_sysclk_in_idle) begin
                    r_next.mode = MODE_IDLE_STOPPED;
                end else if (halt_req) begin
                    r_next.mode = MODE_IDLE_RUNNING;
                end else begin
                    r_next.mode = r_next.active_fast ? MODE_NORMAL : MODE_SLOW;
                end
            end
            MODE_IDLE_STOPPED, MODE_IDLE_RUNNING, MODE_STOP_WATCHDOG, MODE_DEEP_STOP: begin
                if (wake_req) begin
                    r_next.mode = r_reg.active_fast ? MODE_NORMAL : MODE_SLOW;
                end
            end
            default: begin
                r_next.mode = MODE_NORMAL;
            end
        endcase

        // Oscillator enables for the coming mode
        r_next.osc.slow_osc_enable = (r_next.mode != MODE_DEEP_STOP)
            && !(r_next.mode == MODE_STOP_WATCHDOG && !watchdog_enable);
        r_next.osc.fast_osc_enable =
            (((r_next.mode == MODE_NORMAL) || (r_next.mode == MODE_SLOW))
                && (r_next.active_fast || want_fast))
            || ((r_next.mode == MODE_IDLE_RUNNING) && r_next.active_fast);

        // Selected source ticks
        mask = div_mask(r_reg.active_shift);
        src_toggle = r_reg.active_fast ? (fast_edge && ((r_reg.div_cnt & mask) == mask))
                                       : slow_edge;
        sys_run = (r_reg.mode == MODE_NORMAL) || (r_reg.mode == MODE_SLOW)
            || (r_reg.mode == MODE_IDLE_RUNNING);
        cpu_run = run_mode;
        tb_run = (r_reg.mode != MODE_DEEP_STOP) && (r_reg.mode != MODE_STOP_WATCHDOG);
        wd_run = r_reg.osc.slow_osc_enable && watchdog_enable;

        // Clocks stop after a high phase, or at once when their oscillator is off
        src_on = r_reg.active_fast ? r_reg.osc.fast_osc_enable : r_reg.osc.slow_osc_enable;
        if (!src_on) begin
            r_next.clk.system_clock = 1'b0;
        end else if (src_toggle) begin
            r_next.clk.system_clock = sys_run ? !r_reg.clk.system_clock : 1'b0;
        end
        r_next.clk.cpu_clock = r_next.clk.system_clock
            && (r_reg.clk.cpu_clock || (cpu_run && !r_reg.clk.system_clock));
        if (!r_reg.osc.slow_osc_enable) begin
            r_next.clk.timebase_clock = 1'b0;
            r_next.clk.watchdog_clock = 1'b0;
        end else if (slow_edge) begin
            r_next.clk.timebase_clock = tb_run ? !r_reg.clk.timebase_clock : 1'b0;
            r_next.clk.watchdog_clock = wd_run ? !r_reg.clk.watchdog_clock : 1'b0;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r_reg <= '0;
            r_reg.mode <= MODE_NORMAL;
            r_reg.divider_select <= DIV_SEL_RESET;
            r_reg.idle_on_halt <= IDLE_ON_HALT_RESET;
            r_reg.fast_clock_select <= FAST_SEL_RESET;
            r_reg.keep_sysclk_in_idle <= KEEP_SYSCLK_RESET;
            r_reg.active_fast <= 1'b1;
            r_reg.osc.fast_osc_enable <= 1'b1;
            r_reg.osc.slow_osc_enable <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    assign reg_rdata = r_reg.rdata;
    assign osc_ctrl = r_reg.osc;
    assign clk_out = r_reg.clk;
    assign mode_status = r_reg.mode;

    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence halt_in_run;
        ((r_reg.mode == MODE_NORMAL) || (r_reg.mode == MODE_SLOW)) && halt_req;
    endsequence

    sequence stopped_low(logic clk_bit);
        !clk_bit ##1 !clk_bit;
    endsequence

    halt_sleep_a: assert property (
        halt_in_run and (!r_reg.idle_on_halt) |=>
            r_reg.mode == ($past(watchdog_enable) ? MODE_STOP_WATCHDOG : MODE_DEEP_STOP))
        else $error("halt with idle off did not sleep");
    halt_idle_stop_a: assert property (
        halt_in_run and (r_reg.idle_on_halt && !r_reg.keep_sysclk_in_idle) |=>
            r_reg.mode == MODE_IDLE_STOPPED)
        else $error("halt did not enter idle stopped");
    halt_idle_run_a: assert property (
        halt_in_run and (r_reg.idle_on_halt && r_reg.keep_sysclk_in_idle) |=>
            r_reg.mode == MODE_IDLE_RUNNING)
        else $error("halt did not enter idle running");
    deep_stop_a: assert property (
        (r_reg.mode == MODE_DEEP_STOP && !r_reg.clk.system_clock) |->
            !r_reg.osc.slow_osc_enable ##1 stopped_low(r_reg.clk.watchdog_clock))
        else $error("clock or slow oscillator alive in deep stop");
    stop_wdt_a: assert property (
        (r_reg.mode == MODE_STOP_WATCHDOG && watchdog_enable)[*2] |->
            r_reg.osc.slow_osc_enable && !r_reg.osc.fast_osc_enable)
        else $error("slow oscillator off in stop with watchdog");
    slow_mode_fast_off_a: assert property (
        (r_reg.mode == MODE_SLOW && !r_reg.active_fast
            && !needs_fast(r_reg.fast_clock_select, r_reg.divider_select)) |=>
            !r_reg.osc.fast_osc_enable || r_reg.mode != MODE_SLOW)
        else $error("fast oscillator kept running in slow mode");
    cpu_gated_a: assert property (
        (r_reg.mode == MODE_IDLE_STOPPED && !r_reg.clk.cpu_clock
            && !r_reg.clk.system_clock) |=> !r_reg.clk.cpu_clock && !r_reg.clk.system_clock)
        else $error("clock toggled in idle stopped");
    switch_ready_a: assert property (
        $rose(r_reg.active_fast) |-> $past(fast_ready) && !$past(r_reg.clk.system_clock))
        else $error("switched to fast source before it was stable");
    idle_run_wdt_a: assert property (
        r_reg.mode == MODE_IDLE_RUNNING |-> r_reg.osc.slow_osc_enable
            && (r_reg.osc.fast_osc_enable == r_reg.active_fast))
        else $error("oscillators wrong in idle running");
    wake_return_a: assert property (
        (!((r_reg.mode == MODE_NORMAL) || (r_reg.mode == MODE_SLOW)) && wake_req) |=>
            r_reg.mode == ($past(r_reg.active_fast) ? MODE_NORMAL : MODE_SLOW))
        else $error("wake did not return to the active source mode");
    deep_stop_clk_a: assert property (
        r_reg.mode == MODE_DEEP_STOP |=> !r_reg.clk.system_clock && !r_reg.clk.cpu_clock
            && !r_reg.clk.timebase_clock)
        else $error("clock running in deep stop");

endmodule

// *** tb/system_clock_and_power_modes_test.sv ***
// Self-checking testbench for the system clock and power mode controller
`timescale 1ns/100ps
module system_clock_and_power_modes_test;
    import clock_power_pkg::*;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    reg_req_t req = '0;
    logic [7:0] reg_rdata;
    logic fast_pin = 1'b0;
    logic slow_pin = 1'b0;
    osc_ctrl_t osc_ctrl;
    logic halt_req = 1'b0;
    logic wake_req = 1'b0;
    logic watchdog_enable = 1'b1;
    clk_out_t clk_out;
    mode_t mode_status;
    int miscompares = 0;
    int total_checks = 0;
    int fcnt = 0;
    int scnt = 0;

    // Short slow-loss timeout so a 16-cycle slow pin counts as alive
    clock_power_ctrl #(.SLOW_TIMEOUT_CYCLES(64)) DUT (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(reg_rdata),
        .fast_rc_osc(fast_pin), .slow_rc_osc(slow_pin), .osc_ctrl(osc_ctrl),
        .halt_req(halt_req), .wake_req(wake_req), .watchdog_enable(watchdog_enable),
        .clk_out(clk_out), .mode_status(mode_status)
    );

    // Clock and reset
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
    end

    // Oscillator pins run only while enabled; fast every 5 cycles, slow every 16
    always @(posedge sys_clk) begin
        if (osc_ctrl.fast_osc_enable !== 1'b1) fcnt <= 0;
        else if (fcnt == 4) begin
            fcnt <= 0;
            fast_pin <= ~fast_pin;
        end else fcnt <= fcnt + 1;
        if (osc_ctrl.slow_osc_enable !== 1'b1) scnt <= 0;
        else if (scnt == 15) begin
            scnt <= 0;
            slow_pin <= ~slow_pin;
        end else scnt <= scnt + 1;
    end

    task automatic fail(input string msg);
        miscompares++;
        $display("[ERR] t=%0t %s", $time, msg);
    endtask

    // Compare tasks, one per kind of result
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", msg, got, exp));
    endtask
    task automatic check_mode(input mode_t got, input mode_t exp, input string msg);
        total_checks++;
        if (got !== exp) fail($sformatf("%s mode %h exp %h", msg, got, exp));
    endtask
    task automatic check_num(input int got, input int exp, input string msg);
        total_checks++;
        if (got != exp) fail($sformatf("%s got %0d exp %0d", msg, got, exp));
    endtask

    // Register port master
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_mode(input mode_t exp, input int limit);
        int k;
        for (k = 0; k < limit && mode_status !== exp; k++) @(posedge sys_clk);
        #1 check_mode(mode_status, exp, "mode wait");
    endtask

    // Cycles between the third and fourth system clock toggles
    task automatic half_period(output int c);
        logic p;
        int k, n, k3;
        n = 0;
        k3 = 0;
        c = 0;
        p = clk_out.system_clock;
        for (k = 0; k < 3000 && n < 4; k++) begin
            @(posedge sys_clk);
            #1;
            if (clk_out.system_clock !== p) begin
                n++;
                p = clk_out.system_clock;
                if (n == 3) k3 = k;
                if (n == 4) c = k - k3;
            end
        end
    endtask

    // Toggle counts of the four generated clocks over n cycles
    task automatic count_tog(input int n, output int ts, output int tc, output int tt,
                             output int tw);
        clk_out_t p, d;
        int k;
        ts = 0;
        tc = 0;
        tt = 0;
        tw = 0;
        p = clk_out;
        for (k = 0; k < n; k++) begin
            @(posedge sys_clk);
            #1 d = p ^ clk_out;
            p = clk_out;
            ts += d.system_clock;
            tc += d.cpu_clock;
            tt += d.timebase_clock;
            tw += d.watchdog_clock;
        end
    endtask

    task automatic t_reset;
        logic [7:0] d;
        check_mode(mode_status, MODE_NORMAL, "reset mode");
        check_val({6'h0, osc_ctrl}, 8'h03, "reset osc enables");
        reg_read(MODE_CTRL_ADDR, d);
        check_val(d & 8'hF3, {DIV_SEL_RESET, 3'h0, IDLE_ON_HALT_RESET, FAST_SEL_RESET},
                  "ctrl reset");
        reg_read(MODE_CTRL_EXT_ADDR, d);
        check_val(d, {KEEP_SYSCLK_RESET, 7'h00}, "ext reset");
        reg_read(MODE_STATUS_ADDR, d);
        check_val(d, 8'h01, "status reset");
    endtask

    task automatic t_regs;
        logic [7:0] d;
        reg_write(MODE_CTRL_ADDR, 8'hFF);
        reg_read(MODE_CTRL_ADDR, d);
        check_val(d & 8'hF3, 8'hE3, "ctrl write");
        reg_write(MODE_CTRL_EXT_ADDR, 8'hFF);
        reg_read(MODE_CTRL_EXT_ADDR, d);
        check_val(d, 8'h80, "ext write");
        reg_write(8'h07, 8'hFF);
        reg_read(8'h07, d);
        check_val(d, 8'h00, "unmapped read");
        reg_write(MODE_CTRL_EXT_ADDR, 8'h00);
        reg_write(MODE_CTRL_ADDR, 8'h03);
    endtask

    task automatic t_dividers;
        int c, code;
        logic [7:0] d;
        reg_read(MODE_CTRL_ADDR, d);
        check_val(d & 8'h0C, 8'h0C, "ready flags");
        @(posedge sys_clk);
        wake_req <= 1'b1;
        @(posedge sys_clk);
        wake_req <= 1'b0;
        #1 check_mode(mode_status, MODE_NORMAL, "wake ignored in run");
        half_period(c);
        check_num(c, 5, "undivided half period");
        for (code = 2; code < 8; code++) begin
            reg_write(MODE_CTRL_ADDR, {code[2:0], 5'h02});
            half_period(c);
            check_num(c, 5 << (8 - code), "divided half period");
            check_mode(mode_status, MODE_NORMAL, "divided mode");
        end
        reg_write(MODE_CTRL_ADDR, 8'h03);
    endtask

    task automatic t_slow;
        int c, ts, tc, tt, tw;
        reg_write(MODE_CTRL_ADDR, 8'h02);
        wait_mode(MODE_SLOW, 2000);
        repeat (4) @(posedge sys_clk);
        check_val({7'h0, osc_ctrl.fast_osc_enable}, 8'h00, "fast osc off");
        half_period(c);
        check_num(c, 16, "slow half period");
        count_tog(200, ts, tc, tt, tw);
        check_val({4'h0, tc > 0, tt > 0, tw > 0, 1'b0}, 8'h0E, "slow clocks");
        reg_write(MODE_CTRL_ADDR, 8'h03);
        wait_mode(MODE_NORMAL, 2000);
        half_period(c);
        check_num(c, 5, "back to fast");
    endtask

    task automatic t_halt;
        logic [2:0] cfg [4] = '{3'b001, 3'b000, 3'b100, 3'b110};
        mode_t exp [4] = '{MODE_STOP_WATCHDOG, MODE_DEEP_STOP, MODE_IDLE_STOPPED,
                           MODE_IDLE_RUNNING};
        logic [7:0] want [4] = '{8'h01, 8'h00, 8'h02, 8'h0A};
        int i, ts, tc, tt, tw;
        for (i = 0; i < 4; i++) begin
            reg_write(MODE_CTRL_ADDR, {6'h00, cfg[i][2], 1'b1});
            reg_write(MODE_CTRL_EXT_ADDR, {cfg[i][1], 7'h00});
            watchdog_enable <= cfg[i][0];
            @(posedge sys_clk);
            halt_req <= 1'b1;
            @(posedge sys_clk);
            halt_req <= 1'b0;
            #1 check_mode(mode_status, exp[i], "halt mode");
            repeat (40) @(posedge sys_clk);
            check_val({7'h0, osc_ctrl.slow_osc_enable}, {7'h0, i != 1}, "slow osc");
            count_tog(300, ts, tc, tt, tw);
            check_val({4'h0, ts > 0, tc > 0, tt > 0, tw > 0}, want[i],
                      "halted clocks");
            @(posedge sys_clk);
            halt_req <= 1'b1;
            @(posedge sys_clk);
            halt_req <= 1'b0;
            #1 check_mode(mode_status, exp[i], "halt ignored");
            @(posedge sys_clk);
            wake_req <= 1'b1;
            @(posedge sys_clk);
            wake_req <= 1'b0;
            wait_mode(MODE_NORMAL, 2000);
        end
        watchdog_enable <= 1'b1;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        @(posedge reset_n);
        t_reset;
        t_regs;
        repeat (400) @(posedge sys_clk);
        t_dividers;
        t_slow;
        t_halt;
        summarize;
    end

    // Watchdog on a hung run
    initial begin
        repeat (80000) @(posedge sys_clk);
        fail("timeout");
        summarize;
    end
endmodule
